// file: hw/mbsc_pkg.sv
// constants and types for the maintenance board state controller
package mbsc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;            // 10 MHz clock
  localparam int unsigned SW_HOLD_MS      = 3500;           // reset switch hold, 3.5 seconds
  localparam int unsigned SW_HOLD_CYCLES  = (SW_HOLD_MS * 1000000) / CLK_PERIOD_NS;  // least time
  localparam int unsigned SW_CNT_W        = 26;             // wide enough for the hold count

  // ---------------------------------------------------------------
  // escape sequence
  // ---------------------------------------------------------------
  localparam logic [7:0] CHAR_CTRL_C      = 8'h03;          // break character
  localparam logic [1:0] CTRL_C_NEEDED    = 2'h3;           // consecutive count to escape
  localparam logic [1:0] CTRL_C_RESET_VAL = 2'h0;           // count after reset

  // ---------------------------------------------------------------
  // operating states, one distinct code each
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MBSC_ST_SELFTEST = 3'b000,
    MBSC_ST_CHECK    = 3'b001,
    MBSC_ST_NORMAL   = 3'b010,
    MBSC_ST_INDEP    = 3'b011,
    MBSC_ST_WAIT_IND = 3'b100,
    MBSC_ST_DOWNLOAD = 3'b101,
    MBSC_ST_DISABLED = 3'b110
  } mbsc_state_e;

  // ---------------------------------------------------------------
  // self-test result encoding
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MBSC_BIST_PASS   = 2'b00,
    MBSC_BIST_MINOR  = 2'b01,
    MBSC_BIST_SEVERE = 2'b10,
    MBSC_BIST_HOSTRK = 2'b11
  } mbsc_bist_e;

  // reported state codes for the state query
  localparam logic [2:0] RPT_NORMAL       = 3'h0;
  localparam logic [2:0] RPT_INDEP        = 3'h1;
  localparam logic [2:0] RPT_NORMAL_IMP   = 3'h2;
  localparam logic [2:0] RPT_INDEP_IMP    = 3'h3;
  localparam logic [2:0] RPT_SELFTEST     = 3'h4;
  localparam logic [2:0] RPT_DOWNLOAD     = 3'h5;
  localparam logic [2:0] RPT_DISABLED     = 3'h6;

endpackage : mbsc_pkg

// file: hw/mbsc_hold_timer.sv
// hold timer: pulses once a level has stood for a given number of cycles
`timescale 1ns/1ps
`default_nettype none
module mbsc_hold_timer
  import mbsc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = SW_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // level watched
  input  wire logic level_in,
  // pulse when held long enough
  output logic      held_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [SW_CNT_W-1:0] cnt;    // cycles the level has stood
    logic                fired;  // one pulse per press
    logic                held;   // registered output
  } mbsc_hold_s;

  mbsc_hold_s st_r;   // current
  mbsc_hold_s st_nxt; // next

  // count while pressed; release rearms
  always_comb begin
    st_nxt      = st_r;
    st_nxt.held = 1'b0;
    if (!level_in) begin
      st_nxt.cnt   = '0;
      st_nxt.fired = 1'b0;
    end else if (!st_r.fired) begin
      if (st_r.cnt >= SW_CNT_W'(HOLD_CYCLES - 1)) begin
        st_nxt.held  = 1'b1;
        st_nxt.fired = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + SW_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign held_out = st_r.held;

endmodule : mbsc_hold_timer
`default_nettype wire

// file: hw/mbsc_state_ctrl.sv
// operating-state controller of the maintenance board
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - lesser self-test fault enters impaired, not disabled
// - impaired still acts as normal or independent
// - query reports combined impaired state, faults separately
// - severe or host-risk fault disables board, modem
// - three ctrl-c go independent, modem kept
// - exit in independent returns normal, drops modem
// - local independent waits for remote disconnect
// - any reset enters self-test then image check
// - intact image hands over, enters normal
// - corrupt image enters download until success
// - download for bad or older image, or on user update request
// - interrupted download leaves image marked corrupt
// - host utility accepted in normal, independent only
// - passing self-test proceeds to normal
// - reset switch held 3.5 s restarts self-test
module mbsc_state_ctrl
  import mbsc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = SW_HOLD_CYCLES,   // reset switch hold, shorten in sim
  parameter int unsigned FAULT_W     = 8                 // hardware fault vector width
) (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // reset sources
  input  wire logic               reset_switch_in,     // faceplate switch level
  input  wire logic               reset_cmd_in,        // reset command pulse
  // self-test
  input  wire logic               bist_done_in,        // result valid pulse
  input  wire logic [1:0]         bist_result_in,      // mbsc_bist_e code
  input  wire logic [FAULT_W-1:0] bist_faults_in,      // fault bits found
  // firmware image check
  input  wire logic               image_done_in,       // check result pulse
  input  wire logic               image_ok_in,         // image intact
  input  wire logic               image_older_in,      // older than platform copy
  input  wire logic               download_done_in,    // download finished
  input  wire logic               download_ok_in,      // download succeeded
  input  wire logic               download_req_in,     // user update request
  // remote terminal
  input  wire logic               rx_valid_in,         // character strobe
  input  wire logic [7:0]         rx_char_in,          // character
  input  wire logic               modem_connected_in,  // carrier present
  input  wire logic               exit_cmd_in,         // exit in independent
  // local console
  input  wire logic               local_indep_cmd_in,  // go independent
  // host utility
  input  wire logic               host_cmd_valid_in,   // host command offered
  // state and status
  output logic [2:0]              state_out,           // encoded state
  output logic                    impaired_out,        // impaired flag
  output logic [2:0]              state_query_out,     // combined report
  output logic [FAULT_W-1:0]      fault_query_out,     // current faults
  output logic                    image_corrupt_out,   // image marked corrupt
  output logic                    flash_write_out,     // rewriting flash
  output logic                    run_main_out,        // main software in control
  output logic                    modem_enable_out,    // modem powered
  output logic                    modem_hangup_out,    // drop call pulse
  output logic                    board_shutdown_out,  // board shut down
  output logic                    host_cmd_accept_out  // host command taken
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    mbsc_state_e        state;      // operating state
    logic               impaired;   // lesser fault seen
    logic [FAULT_W-1:0] faults;     // latched fault bits
    logic               corrupt;    // image marking
    logic [1:0]         ctrlc;      // consecutive ctrl-c count
    logic               hangup;     // drop call pulse
    logic               accept;     // host command accept pulse
    logic [2:0]         query;      // reported state
    logic               flash;      // rewriting flash
    logic               runm;       // main software in control
    logic               men;        // modem powered
    logic               shut;       // board shut down
  } mbsc_ctrl_s;

  mbsc_ctrl_s st_r;   // current
  mbsc_ctrl_s st_nxt; // next

  logic sw_held;      // switch held long enough

  // ---------------------------------------------------------------
  // reset switch hold timer
  // ---------------------------------------------------------------
  // long press detection
  mbsc_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .level_in (reset_switch_in),
    .held_out (sw_held)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.hangup = 1'b0;
    st_nxt.accept = 1'b0;
    // escape counting in normal only, so a half run never outlives a state change
    if (st_r.state != MBSC_ST_NORMAL) begin
      st_nxt.ctrlc = CTRL_C_RESET_VAL;
    end else if (rx_valid_in && rx_char_in == CHAR_CTRL_C) begin
      st_nxt.ctrlc = st_r.ctrlc + 2'h1;
    end else if (rx_valid_in) begin
      st_nxt.ctrlc = CTRL_C_RESET_VAL;
    end
    st_nxt.accept = host_cmd_valid_in &&
                    ((st_r.state == MBSC_ST_NORMAL) || (st_r.state == MBSC_ST_INDEP));
    unique case (st_r.state)
      MBSC_ST_SELFTEST: begin
        if (bist_done_in) begin
          st_nxt.faults = bist_faults_in;
          unique case (mbsc_bist_e'(bist_result_in))
            // pass goes on to image check, then normal
            MBSC_BIST_PASS:   st_nxt.state = MBSC_ST_CHECK;
            MBSC_BIST_MINOR: begin
              st_nxt.impaired = 1'b1;
              st_nxt.state    = MBSC_ST_CHECK;
            end
            MBSC_BIST_SEVERE: st_nxt.state = MBSC_ST_DISABLED;
            MBSC_BIST_HOSTRK: st_nxt.state = MBSC_ST_DISABLED;
          endcase
        end
      end
      MBSC_ST_CHECK: begin
        if (image_done_in) begin
          // download only for bad, older or marked-corrupt image
          if (!image_ok_in || image_older_in || st_r.corrupt) begin
            st_nxt.state = MBSC_ST_DOWNLOAD;
          end else begin
            st_nxt.state = MBSC_ST_NORMAL;
          end
        end
      end
      MBSC_ST_NORMAL: begin
        if (download_req_in) begin
          st_nxt.state = MBSC_ST_DOWNLOAD;
        // third ctrl-c enters independent, call kept
        end else if (rx_valid_in && rx_char_in == CHAR_CTRL_C &&
                     st_r.ctrlc == CTRL_C_NEEDED - 2'h1) begin
          st_nxt.state = MBSC_ST_INDEP;
          st_nxt.ctrlc = CTRL_C_RESET_VAL;
        // local request waits while a call is up
        end else if (local_indep_cmd_in) begin
          st_nxt.state = modem_connected_in ? MBSC_ST_WAIT_IND : MBSC_ST_INDEP;
        end
      end
      MBSC_ST_WAIT_IND: begin
        // enter once remote user hangs up
        if (!modem_connected_in) begin
          st_nxt.state = MBSC_ST_INDEP;
        end
      end
      MBSC_ST_INDEP: begin
        // exit: back to normal, drop call
        if (exit_cmd_in) begin
          st_nxt.state  = MBSC_ST_NORMAL;
          st_nxt.hangup = 1'b1;
        end
      end
      MBSC_ST_DOWNLOAD: begin
        st_nxt.corrupt = 1'b1;
        if (download_done_in && download_ok_in) begin
          st_nxt.corrupt = 1'b0;
          st_nxt.state   = MBSC_ST_NORMAL;
        end
      end
      MBSC_ST_DISABLED: begin
        // only a reset leaves this state
      end
      default: st_nxt.state = MBSC_ST_DISABLED;
    endcase
    // reset command or long press restarts self-test
    if (reset_cmd_in || sw_held) begin
      st_nxt.state    = MBSC_ST_SELFTEST;
      st_nxt.impaired = 1'b0;
      st_nxt.faults   = '0;
      st_nxt.ctrlc    = CTRL_C_RESET_VAL;
    end
    // status flags follow the next state
    st_nxt.flash = (st_nxt.state == MBSC_ST_DOWNLOAD);
    st_nxt.runm  = (st_nxt.state inside {MBSC_ST_NORMAL, MBSC_ST_INDEP, MBSC_ST_WAIT_IND});
    st_nxt.men   = (st_nxt.state != MBSC_ST_DISABLED);
    st_nxt.shut  = (st_nxt.state == MBSC_ST_DISABLED);
    // impaired reports as normal or independent
    unique case (st_nxt.state)
      MBSC_ST_NORMAL:   st_nxt.query = st_nxt.impaired ? RPT_NORMAL_IMP : RPT_NORMAL;
      MBSC_ST_WAIT_IND: st_nxt.query = st_nxt.impaired ? RPT_NORMAL_IMP : RPT_NORMAL;
      MBSC_ST_INDEP:    st_nxt.query = st_nxt.impaired ? RPT_INDEP_IMP : RPT_INDEP;
      MBSC_ST_DOWNLOAD: st_nxt.query = RPT_DOWNLOAD;
      MBSC_ST_DISABLED: st_nxt.query = RPT_DISABLED;
      default:          st_nxt.query = RPT_SELFTEST;
    endcase
  end

  // ---------------------------------------------------------------
  // register; corrupt marking kept across reset (nonvolatile)
  // ---------------------------------------------------------------
  // reset enters self-test
  // one encoded state, separate impaired flag
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r.state    <= MBSC_ST_SELFTEST;
      st_r.impaired <= 1'b0;
      st_r.faults   <= '0;
      st_r.ctrlc    <= CTRL_C_RESET_VAL;
      st_r.hangup   <= 1'b0;
      st_r.accept   <= 1'b0;
      st_r.query    <= RPT_SELFTEST;
      st_r.flash    <= 1'b0;
      st_r.runm     <= 1'b0;
      st_r.men      <= 1'b1;
      st_r.shut     <= 1'b0;
      st_r.corrupt  <= st_nxt.corrupt;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from the state register
  // ---------------------------------------------------------------
  assign state_out           = st_r.state;
  assign impaired_out        = st_r.impaired;
  assign state_query_out     = st_r.query;
  assign fault_query_out     = st_r.faults;
  assign image_corrupt_out   = st_r.corrupt;
  assign host_cmd_accept_out = st_r.accept;
  assign modem_hangup_out    = st_r.hangup;
  // status flags registered, no decode after the flops
  assign flash_write_out     = st_r.flash;
  assign run_main_out        = st_r.runm;
  assign modem_enable_out    = st_r.men;
  assign board_shutdown_out  = st_r.shut;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  minor_impairs_a: assert property (
    st_r.state == MBSC_ST_SELFTEST && bist_done_in && bist_result_in == MBSC_BIST_MINOR &&
    !reset_cmd_in && !sw_held |=> impaired_out && state_out == MBSC_ST_CHECK)
    else $error("minor fault did not impair");
  impaired_report_a: assert property (
    impaired_out && state_out == MBSC_ST_INDEP |-> state_query_out == RPT_INDEP_IMP)
    else $error("impaired independent misreported");
  severe_disables_a: assert property (
    st_r.state == MBSC_ST_SELFTEST && bist_done_in && bist_result_in[1] && !reset_cmd_in && !sw_held
    |=> board_shutdown_out && !modem_enable_out)
    else $error("severe fault did not disable");
  escape_indep_a: assert property (
    state_out == MBSC_ST_NORMAL && st_r.ctrlc == 2'h2 && rx_valid_in && rx_char_in == CHAR_CTRL_C &&
    !download_req_in && !reset_cmd_in && !sw_held |=> state_out == MBSC_ST_INDEP && !modem_hangup_out)
    else $error("escape sequence not honoured");
  exit_hangup_a: assert property (
    state_out == MBSC_ST_INDEP && exit_cmd_in && !reset_cmd_in && !sw_held
    |=> state_out == MBSC_ST_NORMAL && modem_hangup_out ##1 !modem_hangup_out)
    else $error("exit did not drop call");
  wait_call_a: assert property (
    state_out == MBSC_ST_WAIT_IND && modem_connected_in && !reset_cmd_in && !sw_held
    |=> state_out == MBSC_ST_WAIT_IND)
    else $error("left wait with call up");
  download_stays_a: assert property (
    state_out == MBSC_ST_DOWNLOAD && !(download_done_in && download_ok_in) && !reset_cmd_in && !sw_held
    |=> state_out == MBSC_ST_DOWNLOAD && image_corrupt_out)
    else $error("download left early");
  host_gate_a: assert property (
    host_cmd_accept_out |-> $past(st_r.state) == MBSC_ST_NORMAL || $past(st_r.state) == MBSC_ST_INDEP)
    else $error("host command accepted in wrong state");

  cov_escape_c:   cover property (state_out == MBSC_ST_NORMAL ##1 state_out == MBSC_ST_INDEP);
  cov_download_c: cover property (state_out == MBSC_ST_DOWNLOAD ##1 state_out == MBSC_ST_NORMAL);
  cov_disable_c:  cover property (state_out == MBSC_ST_DISABLED);
  cov_wait_c:     cover property (state_out == MBSC_ST_WAIT_IND ##1 state_out == MBSC_ST_INDEP);

endmodule : mbsc_state_ctrl
`default_nettype wire

// file: tb/mbsc_far_model.sv
// far-side model: host platform answers for self-test, image check, download
`timescale 1ns/1ps
`default_nettype none
module mbsc_far_model
  import mbsc_pkg::*;
#(
  parameter logic [7:0] FAULT_PAT = 8'hA5  // fault bits reported with a result
) (
  // clock, reset, observed state
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] state_in,
  // answers chosen by the bench
  input  wire logic [1:0] code_in,
  input  wire logic       ok_in,
  input  wire logic       older_in,
  input  wire logic       dl_ok_in,
  input  wire logic [3:0] delay_in,
  // answer pulses and their data
  output logic            bist_done_out,
  output logic [1:0]      bist_result_out,
  output logic [7:0]      faults_out,
  output logic            image_done_out,
  output logic            image_ok_out,
  output logic            image_older_out,
  output logic            dl_done_out,
  output logic            dl_ok_out
);
  logic [2:0] last_r;  // state seen last cycle
  int         cnt;     // cycles spent in the state
  logic       fire;    // answer due this cycle
  initial begin
    last_r = 3'h0;
    cnt = 0;
  end
  // -------------------------------------------------------------
  // one answer per state entry, delay_in cycles late
  // -------------------------------------------------------------
  // answers self-test, image check and download
  always @(posedge clk_in) begin
    #1;
    cnt = (reset_in || state_in != last_r) ? 0 : cnt + 1;
    last_r = state_in;
    fire = (cnt == delay_in) && !reset_in;
    bist_done_out = fire && state_in == MBSC_ST_SELFTEST;
    // data off the strobe shows the inverse, never a stale copy
    bist_result_out = bist_done_out ? code_in : ~code_in;
    faults_out = bist_done_out ? FAULT_PAT : ~FAULT_PAT;
    image_done_out = fire && state_in == MBSC_ST_CHECK;
    image_ok_out = image_done_out ? ok_in : ~ok_in;
    image_older_out = image_done_out ? older_in : ~older_in;
    dl_done_out = fire && state_in == MBSC_ST_DOWNLOAD;
    dl_ok_out = dl_done_out ? dl_ok_in : ~dl_ok_in;
  end
endmodule : mbsc_far_model
`default_nettype wire

// file: tb/test_maintenance_board_state_control.sv
// self-checking bench for the operating-state controller
`timescale 1ns/1ps
`default_nettype none
module test_maintenance_board_state_control
  import mbsc_pkg::*;
;
  localparam logic [7:0] FAULTS = 8'hA5;  // pattern the far side reports
  typedef struct packed {
    logic [1:0] code; logic ok; logic older; logic [2:0] st; logic [2:0] qry;
    logic imp; logic men; logic shut; logic acc;
  } mbsc_row_s;
  // result of each self-test and image outcome
  localparam mbsc_row_s ROWS [5] = '{
    '{MBSC_BIST_PASS, 1'h1, 1'h0, MBSC_ST_NORMAL, RPT_NORMAL, 1'h0, 1'h1, 1'h0, 1'h1},
    '{MBSC_BIST_MINOR, 1'h1, 1'h0, MBSC_ST_NORMAL, RPT_NORMAL_IMP, 1'h1, 1'h1, 1'h0, 1'h1},
    '{MBSC_BIST_SEVERE, 1'h1, 1'h0, MBSC_ST_DISABLED, RPT_DISABLED, 1'h0, 1'h0, 1'h1, 1'h0},
    '{MBSC_BIST_HOSTRK, 1'h1, 1'h0, MBSC_ST_DISABLED, RPT_DISABLED, 1'h0, 1'h0, 1'h1, 1'h0},
    '{MBSC_BIST_PASS, 1'h1, 1'h1, MBSC_ST_DOWNLOAD, RPT_DOWNLOAD, 1'h0, 1'h1, 1'h0, 1'h0}};
  logic clk_in, reset_in, reset_switch_in, reset_cmd_in, bist_done_in, image_done_in;
  logic image_ok_in, image_older_in, download_done_in, download_ok_in, download_req_in;
  logic rx_valid_in, modem_connected_in, exit_cmd_in, local_indep_cmd_in, host_cmd_valid_in;
  logic [1:0] bist_result_in, code;
  logic [7:0] bist_faults_in, rx_char_in, fault_query_out;
  logic [2:0] state_out, state_query_out;
  logic impaired_out, image_corrupt_out, flash_write_out, run_main_out, modem_enable_out;
  logic modem_hangup_out, board_shutdown_out, host_cmd_accept_out, ok, older, dl_ok;
  logic [3:0] dly;
  int failures = 0;
  int checks_done = 0;
  // -------------------------------------------------------------
  // design and far side
  // -------------------------------------------------------------
  mbsc_state_ctrl #(.HOLD_CYCLES(20), .FAULT_W(8)) u_mbsc_state_ctrl (
    .clk_in(clk_in), .reset_in(reset_in), .reset_switch_in(reset_switch_in),
    .reset_cmd_in(reset_cmd_in), .bist_done_in(bist_done_in), .bist_result_in(bist_result_in),
    .bist_faults_in(bist_faults_in), .image_done_in(image_done_in), .image_ok_in(image_ok_in),
    .image_older_in(image_older_in), .download_done_in(download_done_in),
    .download_ok_in(download_ok_in), .download_req_in(download_req_in), .rx_valid_in(rx_valid_in),
    .rx_char_in(rx_char_in), .modem_connected_in(modem_connected_in), .exit_cmd_in(exit_cmd_in),
    .local_indep_cmd_in(local_indep_cmd_in), .host_cmd_valid_in(host_cmd_valid_in),
    .state_out(state_out), .impaired_out(impaired_out), .state_query_out(state_query_out),
    .fault_query_out(fault_query_out), .image_corrupt_out(image_corrupt_out),
    .flash_write_out(flash_write_out), .run_main_out(run_main_out),
    .modem_enable_out(modem_enable_out), .modem_hangup_out(modem_hangup_out),
    .board_shutdown_out(board_shutdown_out), .host_cmd_accept_out(host_cmd_accept_out));
  mbsc_far_model #(.FAULT_PAT(FAULTS)) u_mbsc_far_model (
    .clk_in(clk_in), .reset_in(reset_in), .state_in(state_out), .code_in(code), .ok_in(ok),
    .older_in(older), .dl_ok_in(dl_ok), .delay_in(dly), .bist_done_out(bist_done_in),
    .bist_result_out(bist_result_in), .faults_out(bist_faults_in), .image_done_out(image_done_in),
    .image_ok_out(image_ok_in), .image_older_out(image_older_in), .dl_done_out(download_done_in),
    .dl_ok_out(download_ok_in));
  // clock, 100 ns period
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic results();
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk_st(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk_st
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk_bit
  task automatic chk_flt(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk_flt
  // inputs move 10 ns after the rising edge
  task automatic tick();
    @(posedge clk_in);
    #10;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
  endtask : pulse
  // bounded wait; running out ends the run
  task automatic wait_state(input logic [2:0] want, input int lim);
    int n;
    n = 0;
    while (state_out !== want && n < lim) begin
      tick();
      n++;
    end
    if (state_out !== want) begin
      chk_st(state_out, want);
      results();
    end
  endtask : wait_state
  task automatic send_char(input logic [7:0] c);
    rx_valid_in = 1'h1;
    rx_char_in = c;
    tick();
  endtask : send_char
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {reset_switch_in, reset_cmd_in, download_req_in, rx_valid_in, modem_connected_in} = 5'h00;
    {exit_cmd_in, local_indep_cmd_in, host_cmd_valid_in, older, dl_ok} = 5'h00;
    reset_in = 1'h1;
    rx_char_in = 8'h00;
    code = MBSC_BIST_PASS;
    ok = 1'h0;
    dly = 4'h3;
    repeat (8) @(posedge clk_in);
    #10 reset_in = 1'h0;
    chk_st(state_out, MBSC_ST_SELFTEST);
    chk_st(state_query_out, RPT_SELFTEST);
    chk_bit(impaired_out, 1'h0);
    chk_bit(modem_enable_out, 1'h1);
    // bad image, failing download keeps us there, then a reset
    wait_state(MBSC_ST_DOWNLOAD, 20);
    chk_bit(flash_write_out, 1'h1);
    repeat (10) tick();
    chk_bit(image_corrupt_out, 1'h1);
    chk_st(state_out, MBSC_ST_DOWNLOAD);
    ok = 1'h1;
    pulse(reset_cmd_in);
    wait_state(MBSC_ST_DOWNLOAD, 20);
    chk_st(state_out, MBSC_ST_DOWNLOAD);
    dl_ok = 1'h1;
    dly = 4'h8;
    wait_state(MBSC_ST_NORMAL, 100);
    chk_bit(image_corrupt_out, 1'h0);
    chk_bit(run_main_out, 1'h1);
    dly = 4'h0;
    // table of self-test and image outcomes
    for (int i = 0; i < 5; i++) begin
      {code, ok, older, dl_ok} = {ROWS[i].code, ROWS[i].ok, ROWS[i].older, 1'h0};
      pulse(reset_cmd_in);
      chk_st(state_out, MBSC_ST_SELFTEST);
      wait_state(ROWS[i].st, 40);
      chk_st(state_query_out, ROWS[i].qry);
      chk_bit(impaired_out, ROWS[i].imp);
      chk_bit(modem_enable_out, ROWS[i].men);
      chk_bit(board_shutdown_out, ROWS[i].shut);
      pulse(host_cmd_valid_in);
      chk_bit(host_cmd_accept_out, ROWS[i].acc);
    end
    // impaired board back in normal through a good download
    {code, ok, older, dl_ok} = {MBSC_BIST_MINOR, 1'h1, 1'h0, 1'h1};
    pulse(reset_cmd_in);
    wait_state(MBSC_ST_NORMAL, 100);
    chk_flt(fault_query_out, FAULTS);
    // broken escape run: another char restarts the count
    send_char(CHAR_CTRL_C);
    send_char(CHAR_CTRL_C);
    send_char(8'h41);
    send_char(CHAR_CTRL_C);
    send_char(CHAR_CTRL_C);
    chk_st(state_out, MBSC_ST_NORMAL);
    send_char(CHAR_CTRL_C);
    rx_valid_in = 1'h0;
    chk_st(state_out, MBSC_ST_INDEP);
    chk_st(state_query_out, RPT_INDEP_IMP);
    chk_bit(modem_hangup_out, 1'h0);
    pulse(host_cmd_valid_in);
    chk_bit(host_cmd_accept_out, 1'h1);
    pulse(exit_cmd_in);
    chk_st(state_out, MBSC_ST_NORMAL);
    chk_bit(modem_hangup_out, 1'h1);
    tick();
    chk_bit(modem_hangup_out, 1'h0);
    // local request waits while the modem is connected
    modem_connected_in = 1'h1;
    pulse(local_indep_cmd_in);
    repeat (5) tick();
    chk_st(state_out, MBSC_ST_WAIT_IND);
    modem_connected_in = 1'h0;
    wait_state(MBSC_ST_INDEP, 4);
    pulse(exit_cmd_in);
    // a half escape run does not outlive a stay in independent
    send_char(CHAR_CTRL_C);
    send_char(CHAR_CTRL_C);
    rx_valid_in = 1'h0;
    pulse(local_indep_cmd_in);
    chk_st(state_out, MBSC_ST_INDEP);
    pulse(exit_cmd_in);
    send_char(CHAR_CTRL_C);
    rx_valid_in = 1'h0;
    chk_st(state_out, MBSC_ST_NORMAL);
    // short switch press is ignored, a long one restarts
    reset_switch_in = 1'h1;
    repeat (15) tick();
    reset_switch_in = 1'h0;
    tick();
    chk_st(state_out, MBSC_ST_NORMAL);
    reset_switch_in = 1'h1;
    wait_state(MBSC_ST_SELFTEST, 30);
    reset_switch_in = 1'h0;
    wait_state(MBSC_ST_NORMAL, 40);
    // user update request, then a board reset in mid-download
    {dl_ok, dly} = {1'h0, 4'h1};
    pulse(download_req_in);
    chk_bit(flash_write_out, 1'h1);
    reset_in = 1'h1;
    repeat (2) tick();
    reset_in = 1'h0;
    chk_st(state_query_out, RPT_SELFTEST);
    chk_bit(impaired_out, 1'h0);
    chk_bit(image_corrupt_out, 1'h1);
    dl_ok = 1'h1;
    wait_state(MBSC_ST_NORMAL, 100);
    chk_bit(image_corrupt_out, 1'h0);
    results();
  end
endmodule : test_maintenance_board_state_control
`default_nettype wire
